/* File: cpu_ops_cfg.svh */
`ifndef CPU_OPS_CFG_SVH
`define CPU_OPS_CFG_SVH

// ****************************************
// Opcode patterns
// ****************************************
`define OP_NOP 14'h0000
`define OP_RESET 14'h0001
`define OP_RETURN 14'h0008
`define OP_RET_IRQ 14'h0009
`define OP_OPTION 14'h0062
`define FMOVE_MASK 14'h3F80
`define FMOVE_VAL 14'h0080
`define ISTORE_MASK 14'h3FF8
`define ISTORE_VAL 14'h0018
`define ISTORE_REL_MASK 14'h3F80
`define ISTORE_REL_VAL 14'h3F80

// ****************************************
// Instruction fields
// ****************************************
`define FADDR_MSB 6
`define MODE_MSB 1
`define NSEL_BIT 2
`define KSEL_BIT 6
`define KOFF_MSB 5
`define WIN0_ADDR 7'h00
`define WIN1_ADDR 7'h01

// ****************************************
// Pointer modes
// ****************************************
`define PMODE_PREINC 2'h0
`define PMODE_PREDEC 2'h1
`define PMODE_POSTINC 2'h2
`define PMODE_POSTDEC 2'h3

// ****************************************
// Register port offsets
// ****************************************
`define A_WREG 8'h00
`define A_PTR0 8'h01
`define A_OPTION 8'h03
`define A_IRQCTL 8'h04
`define A_PWRCTL 8'h05
`define A_STATUS 8'h06
`define A_PC 8'h07
`define A_PUSH 8'h08
`define A_SP 8'h09
`define A_MADDR 8'h0A
`define A_MDATA 8'h0B

// ****************************************
// Bits and reset values
// ****************************************
`define IRQ_EN_BIT 7
`define RI_BIT 0
`define OPTION_RST 8'hFF
`define IRQCTL_RST 8'h00
`define PWRCTL_RST 8'h01
`define PC_RST 16'h0000
`define PTR_RST 16'h0000

`endif

/* File: cpu_ops_pkg.sv */
package cpu_ops_pkg;

  typedef enum logic [3:0] {
    k_nop, k_move_file, k_store_ind, k_store_rel, k_option, k_reset, k_ret_irq, k_return, k_other
  } op_kind_t;

  typedef struct packed {
    op_kind_t kind;
    logic [6:0] faddr;
    logic psel;
    logic [1:0] mode;
    logic [5:0] koff;
  } dec_t;

  typedef struct packed {
    logic [15:0] ea;
    logic [15:0] nxt;
  } ptr_res_t;

  typedef enum logic {st_run, st_ret2} exec_state_t;

endpackage

/* File: ptr_calc.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cpu_ops_cfg.svh"

module ptr_calc import cpu_ops_pkg::*; (
  input wire logic [15:0] ptr_i,
  input wire logic [1:0] mode_i,
  input wire logic rel_i,
  input wire logic [5:0] koff_i,
  output ptr_res_t res_o
);

  logic [15:0] inc;
  logic [15:0] dec;
  logic [15:0] koff_ext;

  // Plain 16-bit adders, so wrap at both ends comes for free
  assign inc = ptr_i + 16'h0001;
  assign dec = ptr_i - 16'h0001;
  assign koff_ext = {{10{koff_i[`KOFF_MSB]}}, koff_i};

  always_comb begin
    res_o.ea = ptr_i;
    res_o.nxt = ptr_i;
    if (rel_i) begin
      res_o.ea = ptr_i + koff_ext;
      res_o.nxt = ptr_i;
    end else begin
      case (mode_i)
        `PMODE_PREINC: begin
          res_o.ea = inc;
          res_o.nxt = inc;
        end
        `PMODE_PREDEC: begin
          res_o.ea = dec;
          res_o.nxt = dec;
        end
        `PMODE_POSTINC: begin
          res_o.ea = ptr_i;
          res_o.nxt = inc;
        end
        default: begin
          res_o.ea = ptr_i;
          res_o.nxt = dec;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* File: cpu_move_and_return_ops.sv */
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "cpu_ops_cfg.svh"

module cpu_move_and_return_ops import cpu_ops_pkg::*; #(
  parameter int DMEM_AW = 8,
  parameter int SP_W = 4,
  parameter int PC_W = 15
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [13:0] instr_i,
  input wire logic instr_valid_i,
  output logic instr_ready_o,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  output logic [PC_W-1:0] program_counter_o,
  output logic [7:0] option_o,
  output logic global_irq_enable_o,
  output logic device_reset_o,
  output logic [2:0] status_o
);

  localparam int STACK_DEPTH = 2 ** SP_W;

  // ****************************************
  // State
  // ****************************************
  logic [7:0] w_r;
  logic [15:0] ptr_r [2];
  logic [7:0] option_r;
  logic [7:0] irqctl_r;
  logic [7:0] pwrctl_r;
  logic [2:0] status_r;
  logic [PC_W-1:0] pc_r;
  logic [SP_W-1:0] sp_r;
  logic [DMEM_AW-1:0] maddr_r;
  logic [15:0] rdata_r;
  logic soft_rst_r;
  exec_state_t state_r;
  logic [7:0] dmem [2 ** DMEM_AW];
  logic [PC_W-1:0] stack [STACK_DEPTH];

  dec_t dec;
  ptr_res_t pres;
  logic accept;
  logic is_ret;
  logic is_ind;
  logic [SP_W-1:0] sp_dec;
  logic [PC_W-1:0] top;
  logic [15:0] sel_ptr;
  logic push_ok;
  logic mem_we;
  logic [DMEM_AW-1:0] mem_wa;
  logic [7:0] mem_wd;

  // ****************************************
  // Decode
  // ****************************************
  always_comb begin
    dec = '0;
    dec.kind = k_other;
    dec.faddr = instr_i[`FADDR_MSB:0];
    dec.mode = instr_i[`MODE_MSB:0];
    dec.psel = instr_i[`NSEL_BIT];
    dec.koff = instr_i[`KOFF_MSB:0];
    if (instr_i == `OP_NOP) begin
      dec.kind = k_nop;
    end else if (instr_i == `OP_RESET) begin
      dec.kind = k_reset;
    end else if (instr_i == `OP_RETURN) begin
      dec.kind = k_return;
    end else if (instr_i == `OP_RET_IRQ) begin
      dec.kind = k_ret_irq;
    end else if (instr_i == `OP_OPTION) begin
      dec.kind = k_option;
    end else if ((instr_i & `FMOVE_MASK) == `FMOVE_VAL) begin
      dec.kind = k_move_file;
    end else if ((instr_i & `ISTORE_MASK) == `ISTORE_VAL) begin
      dec.kind = k_store_ind;
    end else if ((instr_i & `ISTORE_REL_MASK) == `ISTORE_REL_VAL) begin
      dec.kind = k_store_rel;
      dec.psel = instr_i[`KSEL_BIT];
    end
  end

  // Unknown words belong to other units here; they only advance the counter
  assign instr_ready_o = (state_r == st_run) && !soft_rst_r;
  assign accept = instr_valid_i && instr_ready_o;
  assign is_ret = (dec.kind == k_ret_irq) || (dec.kind == k_return);
  assign is_ind = (dec.kind == k_store_ind) || (dec.kind == k_store_rel);
  assign sp_dec = sp_r - SP_W'(1);
  assign top = stack[sp_dec];
  assign sel_ptr = ptr_r[dec.psel];
  assign push_ok = wr_i && (addr_i == `A_PUSH) && !(accept && is_ret) && !soft_rst_r;

  ptr_calc u_ptr_calc (
    .ptr_i(sel_ptr),
    .mode_i(dec.mode),
    .rel_i(dec.kind == k_store_rel),
    .koff_i(dec.koff),
    .res_o(pres)
  );

  // ****************************************
  // Data memory
  // ****************************************
  always_comb begin
    mem_we = 1'b0;
    mem_wa = maddr_r;
    mem_wd = wdata_i[7:0];
    if (accept && dec.kind == k_move_file) begin
      mem_we = 1'b1;
      mem_wd = w_r;
      if (dec.faddr == `WIN0_ADDR) begin
        mem_wa = ptr_r[0][DMEM_AW-1:0];
      end else if (dec.faddr == `WIN1_ADDR) begin
        mem_wa = ptr_r[1][DMEM_AW-1:0];
      end else begin
        mem_wa = DMEM_AW'(dec.faddr);
      end
    end else if (accept && is_ind) begin
      mem_we = 1'b1;
      mem_wd = w_r;
      mem_wa = pres.ea[DMEM_AW-1:0];
    end else if (wr_i && addr_i == `A_MDATA) begin
      mem_we = 1'b1;
    end
  end

  // No reset on the array: software must not rely on power-up contents
  always_ff @(posedge clk_sys_i) begin
    if (mem_we) begin
      dmem[mem_wa] <= mem_wd;
    end
  end

  // ****************************************
  // Return stack
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (push_ok) begin
      stack[sp_r] <= wdata_i[PC_W-1:0];
    end
  end

  // Over- and underflow wrap silently
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sp_r <= '0;
    end else if (soft_rst_r) begin
      sp_r <= '0;
    end else if (accept && is_ret) begin
      sp_r <= sp_dec;
    end else if (push_ok) begin
      sp_r <= sp_r + SP_W'(1);
    end
  end

  // ****************************************
  // Program counter and sequencing
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pc_r <= PC_W'(`PC_RST);
    end else if (soft_rst_r) begin
      pc_r <= PC_W'(`PC_RST);
    end else if (accept) begin
      if (is_ret) begin
        pc_r <= top;
      end else begin
        pc_r <= pc_r + PC_W'(1);
      end
    end else if (wr_i && addr_i == `A_PC) begin
      pc_r <= wdata_i[PC_W-1:0];
    end
  end

  // Second return cycle is dead: the fetched word after a return is stale
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= st_run;
    end else begin
      case (state_r)
        st_run: state_r <= (accept && is_ret) ? st_ret2 : st_run;
        default: state_r <= st_run;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= accept && (dec.kind == k_reset);
    end
  end

  // ****************************************
  // Working, pointer and control registers
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      w_r <= 8'h00;
    end else if (soft_rst_r) begin
      w_r <= 8'h00;
    end else if (wr_i && addr_i == `A_WREG) begin
      w_r <= wdata_i[7:0];
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_ptr
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        ptr_r[i] <= `PTR_RST;
      end else if (soft_rst_r) begin
        ptr_r[i] <= `PTR_RST;
      end else if (accept && is_ind && dec.psel == 1'(i)) begin
        ptr_r[i] <= pres.nxt;
      end else if (wr_i && addr_i == `A_PTR0 + 8'(i)) begin
        ptr_r[i] <= wdata_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      option_r <= `OPTION_RST;
    end else if (soft_rst_r) begin
      option_r <= `OPTION_RST;
    end else if (accept && dec.kind == k_option) begin
      option_r <= w_r;
    end else if (wr_i && addr_i == `A_OPTION) begin
      option_r <= wdata_i[7:0];
    end
  end

  // Hardware set of the enable wins over a same-cycle software write
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irqctl_r <= `IRQCTL_RST;
    end else if (soft_rst_r) begin
      irqctl_r <= `IRQCTL_RST;
    end else begin
      if (wr_i && addr_i == `A_IRQCTL) begin
        irqctl_r <= wdata_i[7:0];
      end
      if (accept && dec.kind == k_ret_irq) begin
        irqctl_r[`IRQ_EN_BIT] <= 1'b1;
      end
    end
  end

  // Only the RI bit clears on the soft reset so software can tell the cause afterwards
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pwrctl_r <= `PWRCTL_RST;
    end else if (soft_rst_r) begin
      pwrctl_r[`RI_BIT] <= 1'b0;
    end else if (wr_i && addr_i == `A_PWRCTL) begin
      pwrctl_r <= wdata_i[7:0];
    end
  end

  // Only software, rst_i and the soft reset of the reset instruction touch the flags; no other instruction does
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      status_r <= 3'h0;
    end else if (soft_rst_r) begin
      status_r <= 3'h0;
    end else if (wr_i && addr_i == `A_STATUS) begin
      status_r <= wdata_i[2:0];
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      maddr_r <= '0;
    end else if (wr_i && addr_i == `A_MADDR) begin
      maddr_r <= wdata_i[DMEM_AW-1:0];
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        `A_WREG: rdata_r <= {8'h00, w_r};
        `A_PTR0: rdata_r <= ptr_r[0];
        `A_PTR0 + 8'h01: rdata_r <= ptr_r[1];
        `A_OPTION: rdata_r <= {8'h00, option_r};
        `A_IRQCTL: rdata_r <= {8'h00, irqctl_r};
        `A_PWRCTL: rdata_r <= {8'h00, pwrctl_r};
        `A_STATUS: rdata_r <= {13'h0000, status_r};
        `A_PC: rdata_r <= 16'(pc_r);
        `A_SP: rdata_r <= 16'(sp_r);
        `A_MADDR: rdata_r <= 16'(maddr_r);
        `A_MDATA: rdata_r <= {8'h00, dmem[maddr_r]};
        default: rdata_r <= 16'h0000;
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  assign rdata_o = rdata_r;
  assign program_counter_o = pc_r;
  assign option_o = option_r;
  assign global_irq_enable_o = irqctl_r[`IRQ_EN_BIT];
  assign device_reset_o = soft_rst_r;
  assign status_o = status_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  sequence s_ret_take;
    accept && is_ret;
  endsequence
  sequence s_soft_take;
    accept && dec.kind == k_reset;
  endsequence
  chk_ret_stall: assert property (s_ret_take |=> !instr_ready_o ##1 instr_ready_o)
    else $error("return not two cycles");
  chk_ret_pc: assert property (s_ret_take |=> pc_r == $past(top))
    else $error("return target wrong");
  chk_soft_rst: assert property (s_soft_take |=> device_reset_o ##1 !pwrctl_r[`RI_BIT])
    else $error("soft reset not applied");
  chk_irq_en: assert property (accept && dec.kind == k_ret_irq |=> global_irq_enable_o)
    else $error("irq enable not set");
  chk_opt_ld: assert property (accept && dec.kind == k_option |=> option_o == $past(w_r))
    else $error("option load wrong");
  chk_flags_kept: assert property (accept && is_ind && !wr_i |=> $stable(status_r))
    else $error("flags changed by store");

endmodule

`default_nettype wire

/* File: prog_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Instruction source, holds each word until taken
// ****************************************
module prog_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [13:0] word_i,
  input wire logic push_i,
  input wire logic ready_i,
  output logic [13:0] instr_o,
  output logic valid_o,
  output logic idle_o,
  output logic [7:0] gap_o
);
  logic [13:0] q[$];
  logic [7:0] cyc;
  logic [7:0] last;
  logic v;
  logic took;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q.delete();
      v = 1'b0;
      took = 1'b0;
      cyc = 8'h00;
      last = 8'h00;
      valid_o <= 1'b0;
      instr_o <= 14'h3FFF;
      idle_o <= 1'b1;
      gap_o <= 8'h00;
    end else begin
      cyc = cyc + 8'h01;
      if (push_i) begin
        q.push_back(word_i);
      end
      took = v && ready_i;
      if (took) begin
        gap_o <= cyc - last;
        last = cyc;
        v = 1'b0;
      end
      if (!v && q.size() > 0) begin
        instr_o <= q.pop_front();
        v = 1'b1;
      end else if (took) begin
        // Released bus shows the inverse, not a stale word
        instr_o <= ~instr_o;
      end
      valid_o <= v;
      idle_o <= !v && q.size() == 0;
    end
  end
endmodule
`default_nettype wire

/* File: test_cpu_move_and_return_ops.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cpu_ops_cfg.svh"

module test_cpu_move_and_return_ops import cpu_ops_pkg::*;;
  logic clk_sys_i, rst_i, instr_valid, instr_ready, wr_i, rd_i, global_irq_enable, dev_rst, push, idle;
  logic [13:0] instr, word;
  logic [7:0] addr_i, option, gap;
  logic [15:0] wdata_i, rdata;
  logic [14:0] pc;
  logic [2:0] status;
  int n_mismatch, cmp_count;
  logic [15:0] tp[5], te[5], tn[5];
  logic [2:0] tw[5];

  cpu_move_and_return_ops DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .instr_i(instr),
    .instr_valid_i(instr_valid), .instr_ready_o(instr_ready), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
    .program_counter_o(pc), .option_o(option), .global_irq_enable_o(global_irq_enable),
    .device_reset_o(dev_rst), .status_o(status));
  prog_mem_model mem (.clk_i(clk_sys_i), .rst_i(rst_i), .word_i(word), .push_i(push),
    .ready_i(instr_ready), .instr_o(instr), .valid_o(instr_valid), .idle_o(idle),
    .gap_o(gap));

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 chk(rdata, exp, "register read");
  endtask

  task automatic mchk(input logic [15:0] ea, input logic [15:0] exp);
    wr(`A_MADDR, ea);
    rd(`A_MDATA, exp);
  endtask

  // Two words go back to back so the second shows the first one's length
  task automatic ex(input logic [13:0] w1, input logic [13:0] w2, input int n);
    int i;
    @(posedge clk_sys_i);
    word <= w1;
    push <= 1'b1;
    if (n > 1) begin
      @(posedge clk_sys_i);
      word <= w2;
    end
    @(posedge clk_sys_i);
    push <= 1'b0;
    i = 0;
    do begin
      @(posedge clk_sys_i);
      i++;
    end while (idle !== 1'b1 && i < 40);
    if (i >= 40) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t instruction not taken", $time);
      test_done();
    end
    repeat (3) @(posedge clk_sys_i);
  endtask

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    push = 1'b0;
    word = 14'h0000;
    addr_i = 8'h00;
    wdata_i = 16'h0000;
    // Pointer, {select, mode} bits, effective address, pointer after
    tp = '{16'h0040, 16'h0040, 16'hFFFF, 16'h0050, 16'h0000};
    tw = '{3'h0, 3'h1, 3'h6, 3'h7, 3'h1};
    te = '{16'h0041, 16'h003F, 16'hFFFF, 16'h0050, 16'hFFFF};
    tn = '{16'h0041, 16'h003F, 16'h0000, 16'h004F, 16'hFFFF};
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(`A_OPTION, {8'h00, `OPTION_RST});
    rd(`A_PWRCTL, {8'h00, `PWRCTL_RST});
    rd(`A_PTR0, `PTR_RST);
    tend("reset");
    wr(`A_STATUS, 16'h0007);
    wr(`A_WREG, 16'h004F);
    ex(`FMOVE_VAL | 14'h0020, 14'h0000, 1);
    mchk(16'h0020, 16'h004F);
    chk({13'h0, status}, 16'h0007, "flags");
    tend("move");
    for (int i = 0; i < 5; i++) begin
      wr(`A_PTR0 + {7'h0, tw[i][2]}, tp[i]);
      wr(`A_WREG, 16'h0060 + 16'(i));
      ex(`ISTORE_VAL | {11'h0, tw[i]}, 14'h0000, 1);
      rd(`A_PTR0 + {7'h0, tw[i][2]}, tn[i]);
      mchk(te[i], 16'h0060 + 16'(i));
      chk({13'h0, status}, 16'h0007, "flags");
    end
    tend("indirect");
    for (int i = 0; i < 2; i++) begin
      wr(`A_PTR0, 16'h0060);
      wr(`A_WREG, 16'h0070 + 16'(i));
      ex(`ISTORE_REL_VAL | (i == 0 ? 14'h0020 : 14'h001F), 14'h0000, 1);
      rd(`A_PTR0, 16'h0060);
      mchk(i == 0 ? 16'h0040 : 16'h007F, 16'h0070 + 16'(i));
    end
    tend("offset");
    wr(`A_PTR0, 16'h0030);
    wr(`A_WREG, 16'h005A);
    ex(`FMOVE_VAL | {7'h0, `WIN0_ADDR}, 14'h0000, 1);
    mchk(16'h0030, 16'h005A);
    tend("window");
    wr(`A_WREG, 16'h004F);
    ex(`OP_OPTION, 14'h0000, 1);
    chk({8'h0, option}, 16'h004F, "option");
    chk({13'h0, status}, 16'h0007, "flags");
    wr(`A_PC, 16'h0010);
    ex(`OP_NOP, `OP_NOP, 2);
    chk({8'h0, gap}, 16'h0001, "nop length");
    chk({1'b0, pc}, 16'h0012, "pc");
    chk({8'h0, option}, 16'h004F, "option kept");
    tend("option nop");
    wr(`A_IRQCTL, 16'h0000);
    wr(`A_PUSH, 16'h0123);
    ex(`OP_RET_IRQ, `OP_NOP, 2);
    chk({8'h0, gap}, 16'h0002, "return length");
    chk({1'b0, pc}, 16'h0124, "pc");
    chk({15'h0, global_irq_enable}, 16'h0001, "irq enable");
    rd(`A_IRQCTL, 16'h0080);
    wr(`A_IRQCTL, 16'h0000);
    wr(`A_PUSH, 16'h0055);
    ex(`OP_RETURN, `OP_NOP, 2);
    chk({8'h0, gap}, 16'h0002, "return length");
    chk({1'b0, pc}, 16'h0056, "pc");
    chk({15'h0, global_irq_enable}, 16'h0000, "irq enable");
    chk({13'h0, status}, 16'h0007, "flags");
    tend("returns");
    ex(`OP_RESET, 14'h0000, 1);
    rd(`A_PWRCTL, 16'h0000);
    chk({8'h0, option}, {8'h00, `OPTION_RST}, "option reset");
    chk({1'b0, pc}, `PC_RST, "pc reset");
    tend("soft reset");
    test_done();
  end
endmodule
`default_nettype wire
